// >>> bench/mdio_sta.sv
// Station management model that frames reads and writes on the management pins
`timescale 1ns/1ps
module mdio_sta (
  // Clock
  input  wire logic i_clk,
  // Device side of the line
  input  wire logic i_mdio,
  input  wire logic i_mdio_oe_n,
  // Pins toward the device
  output logic      o_mdc,
  output wire logic o_line
);
  logic drv_en;
  logic drv_v;
  // Pulled-up line: a released line floats high, so a silent device reads as ones
  assign o_line = !i_mdio_oe_n ? i_mdio : (drv_en ? drv_v : 1'b1);
  initial begin
    o_mdc  = 1'b1;
    drv_en = 1'b0;
    drv_v  = 1'b1;
  end
  // One management clock, five system clocks a phase; sample just before the rise
  task automatic mbit(input logic en, input logic v, output logic seen);
    @(negedge i_clk);
    o_mdc  = 1'b0;
    drv_en = en;
    drv_v  = v;
    repeat (5) @(negedge i_clk);
    seen  = o_line;
    o_mdc = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask : mbit
  // Whole frame; the line is released from the turnaround of a read
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [21:0] hdr;
    logic        s;
    hdr = {8'hff, 2'b01, op, phy, rg};
    for (int i = 21; i >= 0; i--) mbit(1'b1, hdr[i], s);
    for (int i = 17; i >= 0; i--) begin
      mbit(op == 2'b01, (i >= 16) ? i[0] : wd[i], s);
      if (i < 16) rd[i] = s;
    end
    drv_en = 1'b0;
    repeat (10) @(negedge i_clk);
  endtask : frame
endmodule : mdio_sta

// >>> bench/mgmt_ctrl_bank_tb.sv
// Self-checking bench for the four-channel control register bank
`timescale 1ns/1ps
module mgmt_ctrl_bank_tb;
  import chan_ctrl_pkg::*;
  logic                sys_clk;
  logic                reset_n;
  wire                 mdc;
  wire                 line_w;
  logic                mdio_out;
  logic                mdio_oe_n;
  logic                pdown;
  logic [CH_COUNT-1:0] ch_reset, neg_en, neg_rs, iso, uni_en, uni_tx;
  int                  err_count = 0;
  int                  total_checks = 0;
  int                  rst_hi [CH_COUNT] = '{default: 0};
  int                  rs_hi [CH_COUNT] = '{default: 0};
  int                  pre;
  logic [15:0]         rd;

  mgmt_ctrl_bank dut (.I_SYS_CLK(sys_clk), .I_RESET_N(reset_n), .I_MDC(mdc), .I_MDIO(line_w),
    .O_MDIO(mdio_out), .O_MDIO_OE_N(mdio_oe_n), .O_CH_RESET(ch_reset), .O_NEG_ENABLE(neg_en),
    .O_NEG_RESTART(neg_rs), .O_ISOLATE(iso), .O_UNIDIR_ENABLE(uni_en), .O_UNIDIR_TX(uni_tx),
    .O_POWER_DOWN(pdown));
  mdio_sta sta (.i_clk(sys_clk), .i_mdio(mdio_out), .i_mdio_oe_n(mdio_oe_n), .o_mdc(mdc),
    .o_line(line_w));

  // ****************************************************************
  // Clock, pulse counters and helpers
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // High cycles are counted, so a stretched or doubled pulse shows up
  always @(posedge sys_clk) begin
    for (int c = 0; c < CH_COUNT; c++) begin
      rst_hi[c] <= rst_hi[c] + int'(ch_reset[c] === 1'b1);
      rs_hi[c]  <= rs_hi[c] + int'(neg_rs[c] === 1'b1);
    end
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input int ch, input logic [4:0] rg, input logic [15:0] d);
    sta.frame(OP_WRITE, PHY_BASE + 5'(ch), rg, d, rd);
  endtask : wr
  task automatic rdc(input int ch, input logic [4:0] rg, input logic [15:0] exp, input string n);
    sta.frame(OP_READ, PHY_BASE + 5'(ch), rg, 16'h0000, rd);
    chk(n, exp, rd);
  endtask : rdc
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  // Watchdog so a hang still reaches the verdict
  initial begin
    repeat (100000) @(posedge sys_clk);
    $display("[FAIL] watchdog expected finish seen timeout");
    err_count++;
    stop_test();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("neg_enable", 16'h000f, {12'h000, neg_en});
    chk("isolate", 16'h000f, {12'h000, iso});
    chk("unidir", 16'h0000, {8'h00, uni_en, uni_tx});
    chk("power_down", 16'h0000, {15'h0000, pdown});
    for (int c = 0; c < CH_COUNT; c++) begin
      rdc(c, REG_CONTROL, 16'h1540, "control reset");
    end
    // Every writable bit set except the module reset
    for (int c = 0; c < CH_COUNT; c++) begin
      pre = rs_hi[c];
      wr(c, REG_CONTROL, 16'h7fff);
      chk("restart pulses", 16'h0001, 16'(rs_hi[c] - pre));
      rdc(c, REG_CONTROL, 16'h5d60, "control all");
    end
    chk("power_down set", 16'h0001, {15'h0000, pdown});
    // Transmit without link needs negotiation off
    wr(1, REG_CONTROL, 16'h0020);
    chk("unidir_tx", 16'h0002, {12'h000, uni_tx});
    chk("unidir_enable", 16'h000f, {12'h000, uni_en});
    chk("neg_enable off", 16'h000d, {12'h000, neg_en});
    chk("isolate off", 16'h000d, {12'h000, iso});
    rdc(1, REG_CONTROL, 16'h0160, "control ch1");
    // Power down survives a plain write, only a module reset clears it
    wr(0, REG_CONTROL, 16'h0000);
    chk("power_down held", 16'h0001, {15'h0000, pdown});
    rdc(0, REG_CONTROL, 16'h0940, "control ch0");
    pre = rst_hi[0];
    wr(0, REG_CONTROL, 16'h8000);
    chk("reset pulses", 16'h0001, 16'(rst_hi[0] - pre));
    chk("power_down clr", 16'h0000, {15'h0000, pdown});
    rdc(0, REG_CONTROL, 16'h1540, "control defaults");
    // Undefined register, absent address and bad operation code
    wr(2, 5'h05, 16'hffff);
    rdc(2, 5'h05, 16'h0000, "undefined reg");
    rdc(2, REG_CONTROL, 16'h5d60, "control ch2");
    sta.frame(OP_READ, 5'h00, REG_CONTROL, 16'h0000, rd);
    chk("no answer", 16'hffff, rd);
    sta.frame(2'h0, PHY_BASE, REG_CONTROL, 16'h0000, rd);
    rdc(0, REG_CONTROL, 16'h1540, "bad op");
    stop_test();
  end
endmodule : mgmt_ctrl_bank_tb

// >>> design/chan_ctrl.sv
// One channel's control register with self-clearing actions
`timescale 1ns/1ps
module chan_ctrl
  import chan_ctrl_pkg::*;
#(
  parameter bit IS_CH0 = 1'b0
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Write strobe and data from the frame engine
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wr_data,
  // Readback and controls
  output logic      [DATA_W-1:0] rd_data,
  output chan_ctrl_type          ctrl
);

  logic spare_hi_r;
  logic bit11_r;
  logic neg_en_r;
  logic isolate_r;
  logic unidir_r;
  logic unidir_tx_r;
  logic mod_rst_r;
  logic restart_r;
  logic mod_wr;
  logic norm_wr;

  // A write with bit 15 set is a module reset; every other write is a plain store
  assign mod_wr  = wr_en & wr_data[BIT_MOD_RESET];
  assign norm_wr = wr_en & ~wr_data[BIT_MOD_RESET];

  // Stored bits; a module reset write forces defaults and overrides the data
  always_ff @(posedge clk) begin
    if (!rst_n || mod_wr) begin
      spare_hi_r <= RST_SPARE;
      bit11_r    <= RST_POWER_DOWN;
      neg_en_r   <= RST_NEG_EN;
      isolate_r  <= RST_ISOLATE;
      unidir_r   <= RST_UNIDIR;
    end else if (norm_wr) begin
      spare_hi_r <= wr_data[BIT_SPARE_HI];
      neg_en_r   <= wr_data[BIT_NEG_EN];
      isolate_r  <= wr_data[BIT_ISOLATE];
      unidir_r   <= wr_data[BIT_UNIDIR];
      // On channel 0 power down can only be cleared by a module reset; other channels store the bit
      if (IS_CH0) begin
        bit11_r <= bit11_r | wr_data[BIT_POWER_DOWN];
      end else begin
        bit11_r <= wr_data[BIT_POWER_DOWN];
      end
    end
  end

  // Transmit without a link only when negotiation is off, kept in step with its inputs
  always_ff @(posedge clk) begin
    if (!rst_n || mod_wr) begin
      unidir_tx_r <= RST_UNIDIR & ~RST_NEG_EN;
    end else if (norm_wr) begin
      unidir_tx_r <= wr_data[BIT_UNIDIR] & ~wr_data[BIT_NEG_EN];
    end
  end

  // Self-clearing actions last one cycle and never read back
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mod_rst_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      mod_rst_r <= mod_wr;
      restart_r <= norm_wr & wr_data[BIT_RESTART];
    end
  end

  // Readback word with fixed speed, duplex and test fields
  always_comb begin
    rd_data                 = '0;
    rd_data[BIT_MOD_RESET]  = 1'b0;
    rd_data[BIT_SPARE_HI]   = spare_hi_r;
    rd_data[BIT_SPEED_LSB]  = FIX_SPEED_LSB;
    rd_data[BIT_NEG_EN]     = neg_en_r;
    rd_data[BIT_POWER_DOWN] = bit11_r;
    rd_data[BIT_ISOLATE]    = isolate_r;
    rd_data[BIT_RESTART]    = 1'b0;
    rd_data[BIT_DUPLEX]     = FIX_DUPLEX;
    rd_data[BIT_COLL_TEST]  = FIX_COLL_TEST;
    rd_data[BIT_SPEED_MSB]  = FIX_SPEED_MSB;
    rd_data[4:0]            = FIX_LOW;
    rd_data[BIT_UNIDIR]     = unidir_r;
  end

  // Controls come straight from the flops above, except power down, which is tied to 0 on every channel but channel 0
  assign ctrl.module_reset  = mod_rst_r;
  assign ctrl.neg_enable    = neg_en_r;
  assign ctrl.neg_restart   = restart_r;
  assign ctrl.isolate       = isolate_r;
  assign ctrl.power_down    = IS_CH0 ? bit11_r : 1'b0;
  assign ctrl.unidir_enable = unidir_r;
  assign ctrl.unidir_tx     = unidir_tx_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_one_pulse(sig);
    sig ##1 !sig;
  endsequence

  a_reset_pulse_once: assert property (@(posedge clk) disable iff (!rst_n)
    mod_wr |=> s_one_pulse(ctrl.module_reset) and (rd_data[BIT_MOD_RESET] == 1'b0))
    else $error("module reset did not pulse once");
  a_spare_stores: assert property (@(posedge clk) disable iff (!rst_n)
    norm_wr |=> rd_data[BIT_SPARE_HI] == $past(wr_data[BIT_SPARE_HI]))
    else $error("spare bit not stored");
  a_speed_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en |=> !rd_data[BIT_SPEED_LSB] && rd_data[BIT_SPEED_MSB])
    else $error("speed field changed");
  a_neg_en_stores: assert property (@(posedge clk) disable iff (!rst_n)
    norm_wr |=> ctrl.neg_enable == $past(wr_data[BIT_NEG_EN]))
    else $error("negotiation enable not stored");
  a_isolate_stores: assert property (@(posedge clk) disable iff (!rst_n)
    norm_wr |=> ctrl.isolate == $past(wr_data[BIT_ISOLATE]))
    else $error("isolate not stored");
  a_restart_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    norm_wr && wr_data[BIT_RESTART] |=> s_one_pulse(ctrl.neg_restart))
    else $error("restart did not pulse once");
  a_duplex_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && !wr_data[BIT_DUPLEX] |=> rd_data[BIT_DUPLEX])
    else $error("duplex bit not one");
  a_coll_test_off: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && wr_data[BIT_COLL_TEST] |=> !rd_data[BIT_COLL_TEST])
    else $error("collision test bit not zero");
  a_unidir_gate: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 ctrl.unidir_tx == (ctrl.unidir_enable && !ctrl.neg_enable))
    else $error("unidirectional transmit mismatch");
  a_low_bits_zero: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && (wr_data[4:0] != 5'h00) |=> rd_data[4:0] == FIX_LOW)
    else $error("low bits not zero");
  a_mod_reset_dflt: assert property (@(posedge clk) disable iff (!rst_n)
    mod_wr |=> ctrl.neg_enable && ctrl.isolate && !ctrl.unidir_enable
               && !rd_data[BIT_SPARE_HI] && !rd_data[BIT_POWER_DOWN])
    else $error("module reset left a bit off default");
  if (IS_CH0) begin : g_pd_check
    a_power_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      ctrl.power_down && !mod_wr |=> ctrl.power_down)
      else $error("power down cleared without module reset");
  end

endmodule : chan_ctrl

// >>> design/chan_ctrl_pkg.sv
// Shared constants, types and field layout of the channel control register bank
package chan_ctrl_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int          CH_COUNT  = 4;
  localparam int          DATA_W    = 16;
  localparam int          SYNC_W    = 2;
  localparam logic [4:0]  PHY_BASE  = 5'h01;   // First channel address, others follow

  // ****************************************************************
  // Register map and frame codes
  // ****************************************************************
  localparam logic [4:0]  REG_CONTROL = 5'h00;
  localparam logic [1:0]  OP_WRITE    = 2'h1;
  localparam logic [1:0]  OP_READ     = 2'h2;
  localparam logic [3:0]  ADDR_LAST   = 4'h9;  // Ten address bits, counted from zero
  localparam logic [3:0]  DATA_LAST   = 4'hf;  // Sixteen data bits
  localparam logic [3:0]  OP_LAST     = 4'h1;  // Two operation code bits
  localparam logic [3:0]  TA_LAST     = 4'h1;  // Two turnaround bits

  // ****************************************************************
  // Control register field positions
  // ****************************************************************
  localparam int BIT_MOD_RESET  = 15;
  localparam int BIT_SPARE_HI   = 14;
  localparam int BIT_SPEED_LSB  = 13;
  localparam int BIT_NEG_EN     = 12;
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_ISOLATE    = 10;
  localparam int BIT_RESTART    = 9;
  localparam int BIT_DUPLEX     = 8;
  localparam int BIT_COLL_TEST  = 7;
  localparam int BIT_SPEED_MSB  = 6;
  localparam int BIT_UNIDIR     = 5;

  // ****************************************************************
  // Reset and fixed values
  // ****************************************************************
  localparam logic RST_SPARE      = 1'b0;
  localparam logic RST_NEG_EN     = 1'b1;
  localparam logic RST_ISOLATE    = 1'b1;
  localparam logic RST_UNIDIR     = 1'b0;
  localparam logic RST_POWER_DOWN = 1'b0;
  localparam logic FIX_SPEED_LSB  = 1'b0;
  localparam logic FIX_SPEED_MSB  = 1'b1;
  localparam logic FIX_DUPLEX     = 1'b1;
  localparam logic FIX_COLL_TEST  = 1'b0;
  localparam logic [4:0] FIX_LOW  = 5'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_OP    = 3'b010,
    ST_ADDR  = 3'b011,
    ST_TA    = 3'b100,
    ST_DATA  = 3'b101
  } frame_state_type;

  typedef struct packed {
    logic module_reset;   // One-cycle pulse
    logic neg_enable;
    logic neg_restart;    // One-cycle pulse
    logic isolate;
    logic power_down;
    logic unidir_enable;
    logic unidir_tx;
  } chan_ctrl_type;

endpackage : chan_ctrl_pkg

// >>> design/mgmt_ctrl_bank.sv
// Four-channel control register bank behind a serial management slave
`timescale 1ns/1ps

// What this block does
// - Writing 1 to bit 15 resets the channel's module and the bit always reads back 0.
// - Bit 14, and bit 11 on channels 1 to 3, store and return what is written, resetting to 0.
// - Bit 13 always reads 0 and bit 6 always reads 1, reporting 1000 Mb/s.
// - Bit 12 enables link negotiation and resets to 1.
// - On channel 0, bit 11 powers the transceiver down and stays set until a module reset.
// - Bit 10 isolates the serial logic from the client interface and resets to 1.
// - Writing 1 to bit 9 with bit 15 clear restarts link negotiation and the bit clears itself.
// - Bit 8 always reads 1 for full duplex.
// - Bit 7 always reads 0 so the collision test stays off.
// - Bit 5 lets the channel transmit without a link when negotiation is off.
// - Bits 4 to 0 always read 0 and ignore writes.
// - Register address 0 selects the control register, with one copy per channel.
// - A frame with operation code 01 writes its 16 data bits into the addressed register.
// - A frame with operation code 10 is a read: the slave drives the line from the turnaround.
// - Undefined register addresses read as zero and cannot be written.
module mgmt_ctrl_bank
  import chan_ctrl_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR_BASE = chan_ctrl_pkg::PHY_BASE
)(
  // Clock and reset
  input  wire logic                                I_SYS_CLK,
  input  wire logic                                I_RESET_N,
  // Management pins
  input  wire logic                                I_MDC,
  input  wire logic                                I_MDIO,
  output logic                                     O_MDIO,
  output logic                                     O_MDIO_OE_N,
  // Per-channel controls
  output logic [chan_ctrl_pkg::CH_COUNT-1:0]       O_CH_RESET,
  output logic [chan_ctrl_pkg::CH_COUNT-1:0]       O_NEG_ENABLE,
  output logic [chan_ctrl_pkg::CH_COUNT-1:0]       O_NEG_RESTART,
  output logic [chan_ctrl_pkg::CH_COUNT-1:0]       O_ISOLATE,
  output logic [chan_ctrl_pkg::CH_COUNT-1:0]       O_UNIDIR_ENABLE,
  output logic [chan_ctrl_pkg::CH_COUNT-1:0]       O_UNIDIR_TX,
  output logic                                     O_POWER_DOWN
);
  import chan_ctrl_pkg::*;

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  // Synchronised pins and the rising edge of the management clock
  logic [SYNC_W-1:0] pins_s;
  logic              mdc_s;
  logic              mdio_s;
  logic              mdc_d_r;
  logic              mdc_rise;

  pin_sync u_sync (
    .clk   (I_SYS_CLK),
    .rst_n (I_RESET_N),
    .d     ({I_MDC, I_MDIO}),
    .q     (pins_s)
  );

  // Pin order on the synchroniser is clock first, then data
  assign mdc_s  = pins_s[1];
  assign mdio_s = pins_s[0];

  // Edge detect works on the second stage only
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESET_N) begin
      mdc_d_r <= 1'b1;
    end else begin
      mdc_d_r <= mdc_s;
    end
  end

  assign mdc_rise = mdc_s & ~mdc_d_r;

  // ****************************************************************
  // Frame engine
  // ****************************************************************
  // Frame state, captured header and the two shift registers
  frame_state_type   state_r;
  logic [3:0]        cnt_r;
  logic [1:0]        op_r;
  logic [8:0]        addr_r;
  logic [9:0]        addr_full;
  logic [4:0]        phy_off;
  logic              phy_hit;
  logic [1:0]        ch_sel;
  logic [1:0]        ch_sel_r;
  logic              rd_act_r;
  logic              wr_act_r;
  logic [DATA_W-1:0] rd_shift_r;
  logic [DATA_W-1:0] wr_shift_r;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] ch_rd [CH_COUNT];
  logic              addr_done;

  // Address as it stands at the last address bit; channel n answers base plus n
  assign addr_full = {addr_r, mdio_s};
  assign phy_off   = addr_full[9:5] - PHY_ADDR_BASE;
  assign phy_hit   = (phy_off < 5'(CH_COUNT));
  assign ch_sel    = phy_off[1:0];
  assign addr_done = mdc_rise && (state_r == ST_ADDR) && (cnt_r == ADDR_LAST);

  // Only address 0 holds a register; all others answer zero
  always_comb begin
    if (addr_full[4:0] == REG_CONTROL) begin
      rd_word = ch_rd[ch_sel];
    end else begin
      rd_word = '0;
    end
  end

  // Frame sequencing on each rising management clock; foreign frames are walked
  // through too, so their data cannot be mistaken for a start pattern
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESET_N) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
    end else if (mdc_rise) begin
      case (state_r)
        ST_IDLE: begin
          if (!mdio_s) begin
            state_r <= ST_START;
          end
        end
        ST_START: begin
          if (mdio_s) begin
            state_r <= ST_OP;
            cnt_r   <= 4'h0;
          end
        end
        ST_OP: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == OP_LAST) begin
            state_r <= ST_ADDR;
            cnt_r   <= 4'h0;
          end
        end
        ST_ADDR: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == ADDR_LAST) begin
            state_r <= ST_TA;
            cnt_r   <= 4'h0;
          end
        end
        ST_TA: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == TA_LAST) begin
            state_r <= ST_DATA;
            cnt_r   <= 4'h0;
          end
        end
        ST_DATA: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == DATA_LAST) begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          cnt_r   <= 4'h0;
        end
      endcase
    end
  end

  // Header capture
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESET_N) begin
      op_r   <= 2'h0;
      addr_r <= 9'h000;
    end else if (mdc_rise && state_r == ST_OP) begin
      op_r <= {op_r[0], mdio_s};
    end else if (mdc_rise && state_r == ST_ADDR) begin
      addr_r <= addr_full[8:0];
    end
  end

  // Decide at the last address bit whether this frame is ours
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESET_N) begin
      rd_act_r <= 1'b0;
      wr_act_r <= 1'b0;
      ch_sel_r <= 2'h0;
    end else if (addr_done) begin
      rd_act_r <= phy_hit && (op_r == OP_READ);
      wr_act_r <= phy_hit && (op_r == OP_WRITE)
                  && (addr_full[4:0] == REG_CONTROL);
      ch_sel_r <= ch_sel;
    end else if (state_r == ST_IDLE) begin
      rd_act_r <= 1'b0;
      wr_act_r <= 1'b0;
    end
  end

  // Read path: release in the first turnaround bit, drive 0 in the second, then data
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESET_N) begin
      rd_shift_r  <= '0;
      O_MDIO      <= 1'b1;
      O_MDIO_OE_N <= 1'b1;
    end else if (addr_done) begin
      rd_shift_r <= rd_word;
    end else if (mdc_rise && rd_act_r) begin
      if (state_r == ST_TA && cnt_r == 4'h0) begin
        O_MDIO      <= 1'b0;
        O_MDIO_OE_N <= 1'b0;
      end else if (state_r == ST_DATA && cnt_r == DATA_LAST) begin
        O_MDIO      <= 1'b1;
        O_MDIO_OE_N <= 1'b1;
      end else if (state_r == ST_TA || state_r == ST_DATA) begin
        O_MDIO     <= rd_shift_r[DATA_W-1];
        rd_shift_r <= {rd_shift_r[DATA_W-2:0], 1'b0};
      end
    end
  end

  // Write path: shift in sixteen bits, strobe the addressed channel once
  logic [CH_COUNT-1:0] wr_en_r;
  logic [DATA_W-1:0]   wr_data_r;

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESET_N) begin
      wr_shift_r <= '0;
      wr_data_r  <= '0;
      wr_en_r    <= '0;
    end else begin
      wr_en_r <= '0;
      if (mdc_rise && state_r == ST_DATA) begin
        wr_shift_r <= {wr_shift_r[DATA_W-2:0], mdio_s};
        if (cnt_r == DATA_LAST && wr_act_r) begin
          wr_data_r         <= {wr_shift_r[DATA_W-2:0], mdio_s};
          wr_en_r[ch_sel_r] <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Channel registers
  // ****************************************************************
  for (genvar ch = 0; ch < CH_COUNT; ch++) begin : g_ch
    chan_ctrl_type ctrl;

    chan_ctrl #(.IS_CH0(ch == 0)) u_chan (
      .clk     (I_SYS_CLK),
      .rst_n   (I_RESET_N),
      .wr_en   (wr_en_r[ch]),
      .wr_data (wr_data_r),
      .rd_data (ch_rd[ch]),
      .ctrl    (ctrl)
    );

    // Controls leave straight from the channel flops
    assign O_CH_RESET[ch]      = ctrl.module_reset;
    assign O_NEG_ENABLE[ch]    = ctrl.neg_enable;
    assign O_NEG_RESTART[ch]   = ctrl.neg_restart;
    assign O_ISOLATE[ch]       = ctrl.isolate;
    assign O_UNIDIR_ENABLE[ch] = ctrl.unidir_enable;
    assign O_UNIDIR_TX[ch]     = ctrl.unidir_tx;
  end

  // Only channel 0 owns a power-down control
  assign O_POWER_DOWN = g_ch[0].ctrl.power_down;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_unmapped_zero: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    addr_done && (addr_full[4:0] != REG_CONTROL) |=> rd_shift_r == '0)
    else $error("unmapped read not zero");
  a_unmapped_nowr: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    addr_done && (addr_full[4:0] != REG_CONTROL) |=> !wr_act_r)
    else $error("unmapped address armed a write");
  a_write_strobe: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    $rose(|wr_en_r) |-> $past(wr_act_r) && $onehot(wr_en_r))
    else $error("write strobe without an armed write");
  a_read_drive: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    $fell(O_MDIO_OE_N) |-> !O_MDIO && rd_act_r && state_r == ST_TA)
    else $error("line driven outside a read turnaround");
  // Nothing on the line moves between detected clock rises
  a_bit_stands: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    !mdc_rise |=> $stable(O_MDIO) && $stable(O_MDIO_OE_N))
    else $error("line changed between clock rises");
  // Each data bit after the first is the next one of the loaded word
  a_data_shift: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    mdc_rise && rd_act_r && state_r == ST_DATA && cnt_r != DATA_LAST
    |=> O_MDIO == $past(rd_shift_r[DATA_W-1]))
    else $error("read bit out of order");
  // The line is handed back after the last data bit
  a_read_release: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    mdc_rise && rd_act_r && state_r == ST_DATA && cnt_r == DATA_LAST
    |=> O_MDIO_OE_N && O_MDIO)
    else $error("line not released after a read");
  // Frames for addresses outside the four channels stay silent
  a_foreign_quiet: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    addr_done && !phy_hit |=> !rd_act_r && !wr_act_r)
    else $error("foreign frame armed an access");
  // Unknown operation codes neither read nor write
  a_bad_op_quiet: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    addr_done && op_r != OP_READ && op_r != OP_WRITE |=> !rd_act_r && !wr_act_r)
    else $error("unknown operation armed an access");
  // A channel strobe only follows the last data bit of a frame
  a_strobe_at_end: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    wr_en_r != '0 |-> $past(mdc_rise) && $past(state_r) == ST_DATA
                      && $past(cnt_r) == DATA_LAST)
    else $error("channel strobe outside the last data bit");

endmodule : mgmt_ctrl_bank

// >>> design/pin_sync.sv
// Two-stage synchroniser for the management clock and data pins
`timescale 1ns/1ps
module pin_sync
  import chan_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Pins in, synchronised out
  input  wire logic [SYNC_W-1:0] d,
  output logic      [SYNC_W-1:0] q
);

  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] q_r;

  // First stage feeds only the second; idle bus level is high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= {SYNC_W{1'b1}};
      q_r    <= {SYNC_W{1'b1}};
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  // Only the second stage leaves the module, so nothing reads a metastable bit
  assign q = q_r;

endmodule : pin_sync
